/* File: design/active_power_energy_accumulator.sv */
`timescale 1ns/100ps
module active_power_energy_accumulator
  import energy_meter_pkg::*;
#(
  parameter int unsigned WAVE_BASE_CYCLES = WAVE_BASE_DEF
)
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   sample_valid,
  input  wire logic signed [CH_W-1:0] current_sample,
  input  wire logic signed [CH_W-1:0] voltage_sample,
  input  wire logic [ADDR_W-1:0]      address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic [31:0]                 readdata,
  output logic                        waitrequest,
  output logic                        irq_n_out,
  output logic                        irq_n_oe,
  output logic signed [PW_W-1:0]      active_power
);

  typedef struct packed {
    logic signed [CH_W:0]     scaled;
    logic                     scaled_valid;
    logic signed [PW_W-1:0]   inst_power;
    logic                     inst_valid;
    logic [ACC_CNT_W-1:0]     acc_cnt;
    logic signed [EN_W-1:0]   energy;
    logic [EN_W-33:0]         energy_hi_shadow;
    logic [PW_W-1:0]          wave;
    logic [WCNT_W-1:0]        wave_cnt;
    logic [1:0]               wave_rate;
    logic [1:0]               wave_src;
    logic [GAIN_W-1:0]        gain;
    logic [IRQ_W-1:0]         status;
    logic [IRQ_W-1:0]         mask;
    logic                     ack;
    logic [31:0]              rdata;
  } state_t;

  state_t st;
  state_t next_st;

  logic signed [PW_W-1:0]     filtered;
  logic signed [FACT_W-1:0]   gain_factor;
  logic signed [CH_W+FACT_W-1:0] scaled_full;
  logic signed [2*CH_W:0]     product;
  logic signed [EN_W-1:0]     power_ext;
  logic signed [EN_W-1:0]     sum;
  logic [IRQ_W-1:0]           events;
  logic [WCNT_W-1:0]          wave_period;
  logic                       wave_tick;
  logic                       bus_req;
  logic                       wr_done;
  logic [31:0]                be_mask;
  logic [31:0]                mode_word;
  logic [31:0]                wr_mode;
  logic [31:0]                wr_gain;
  logic [31:0]                wr_mask;

  power_lowpass_filter u_lpf (
    .clk      (clk),
    .reset    (reset),
    .in_valid (st.inst_valid),
    .in_data  (st.inst_power),
    .out_data (filtered)
  );

  // Byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [31:0] lanes);
    merge = (old_val & ~lanes) | (new_val & lanes);
  endfunction : merge

  always_comb begin
    be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
               {8{byteenable[1]}}, {8{byteenable[0]}}};
  end

  // Gain and instantaneous power
  always_comb begin
    gain_factor = GAIN_ONE + {{(FACT_W-GAIN_W){st.gain[GAIN_W-1]}}, st.gain};
    scaled_full = current_sample * gain_factor;
    product     = st.scaled * voltage_sample;
  end

  // Accumulation arithmetic
  always_comb begin
    power_ext = {{(EN_W-PW_W){filtered[PW_W-1]}}, filtered};
    sum       = st.energy + power_ext;
  end

  // Waveform rate
  always_comb begin
    wave_period = WCNT_W'(WAVE_BASE_CYCLES << st.wave_rate);
    wave_tick   = (st.wave_cnt == wave_period - 16'h0001);
  end

  // Bus handshake: one wait cycle then completion
  always_comb begin
    bus_req     = read | write;
    waitrequest = bus_req & ~st.ack;
    wr_done     = write & st.ack;
  end

  always_comb begin
    mode_word = 32'h0000_0000;
    mode_word[MODE_RATE_LSB +: 2] = st.wave_rate;
    mode_word[MODE_SRC_LSB +: 2]  = st.wave_src;
    wr_mode = merge(mode_word, writedata, be_mask);
    wr_gain = merge({20'h0_0000, st.gain}, writedata, be_mask);
    wr_mask = merge({28'h000_0000, st.mask}, writedata, be_mask);
  end

  always_comb begin
    next_st = st;
    events  = '0;

    // Pipeline of gain and multiply
    next_st.scaled_valid = sample_valid;
    if (sample_valid) begin
      next_st.scaled = scaled_full[CH_W+GAIN_SHIFT:GAIN_SHIFT];
    end
    next_st.inst_valid = st.scaled_valid;
    if (st.scaled_valid) begin
      next_st.inst_power = product[2*CH_W:PROD_LSB];
    end

    // Energy accumulation
    if (st.acc_cnt == ACC_CNT_W'(ACC_CYCLES - 1)) begin
      next_st.acc_cnt = '0;
      next_st.energy  = sum;
      if (!st.energy[EN_W-1] && !power_ext[EN_W-1] && sum[EN_W-1]) begin
        events[ST_OVF] = 1'b1;
      end
      if (st.energy[EN_W-1] && power_ext[EN_W-1] && !sum[EN_W-1]) begin
        events[ST_UDF] = 1'b1;
      end
      if ((st.energy[EN_W-1 -: 2] == 2'b00 && sum[EN_W-1 -: 2] == 2'b01) ||
          (st.energy[EN_W-1 -: 2] == 2'b11 && sum[EN_W-1 -: 2] == 2'b10)) begin
        events[ST_HALF] = 1'b1;
      end
    end else begin
      next_st.acc_cnt = st.acc_cnt + 6'h01;
    end

    // Waveform sampling of active power
    if (wave_tick) begin
      next_st.wave_cnt = '0;
      if (st.wave_src == WAVE_SRC_POWER && st.mask[ST_WAVE]) begin
        next_st.wave    = filtered;
        events[ST_WAVE] = 1'b1;
      end
    end else begin
      next_st.wave_cnt = st.wave_cnt + 16'h0001;
    end

    // Bus access
    next_st.ack = bus_req & ~st.ack;
    if (read && !st.ack) begin
      case (address)
        OFS_ENERGY_LO: begin
          next_st.rdata            = st.energy[31:0];
          next_st.energy_hi_shadow = st.energy[EN_W-1:32];
        end
        OFS_ENERGY_HI: begin
          next_st.rdata = {24'h00_0000, st.energy_hi_shadow};
        end
        OFS_WAVEFORM: begin
          next_st.rdata = {8'h00, st.wave};
        end
        OFS_MODE: begin
          next_st.rdata = mode_word;
        end
        OFS_GAIN: begin
          next_st.rdata = {20'h0_0000, st.gain};
        end
        OFS_STATUS: begin
          next_st.rdata = {28'h000_0000, st.status};
        end
        OFS_MASK: begin
          next_st.rdata = {28'h000_0000, st.mask};
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end

    next_st.status = st.status;
    if (wr_done) begin
      case (address)
        OFS_MODE: begin
          next_st.wave_rate = wr_mode[MODE_RATE_LSB +: 2];
          next_st.wave_src  = wr_mode[MODE_SRC_LSB +: 2];
        end
        OFS_GAIN: begin
          next_st.gain = wr_gain[GAIN_W-1:0];
        end
        OFS_STATUS: begin
          next_st.status = st.status & ~(writedata[IRQ_W-1:0] & be_mask[IRQ_W-1:0]);
        end
        OFS_MASK: begin
          next_st.mask = wr_mask[IRQ_W-1:0];
        end
        default: begin
          next_st.status = st.status;
        end
      endcase
    end
    // Set wins over clear
    next_st.status = next_st.status | events;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st           <= '0;
      st.energy    <= ENERGY_RST;
      st.gain      <= GAIN_RST;
      st.wave_rate <= RATE_RST;
      st.wave_src  <= SRC_RST;
      st.mask      <= MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  // Open-drain active-low interrupt: pull low while an enabled flag is set
  assign irq_n_out    = 1'b0;
  assign irq_n_oe     = |(st.status & st.mask);
  assign readdata     = st.rdata;
  assign active_power = filtered;

endmodule : active_power_energy_accumulator

/* File: design/energy_meter_pkg.sv */
package energy_meter_pkg;

  // Clock and timing
  localparam int          CLK_PERIOD_NS    = 20;
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int          ACC_PERIOD_NS    = 1100;
  localparam int          ACC_CYCLES       = (ACC_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1
                                             : ACC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          ACC_CNT_W        = 6;
  localparam int unsigned WAVE_MAX_RATE_HZ = 27_900;
  localparam int unsigned WAVE_BASE_DEF    = CLK_HZ / WAVE_MAX_RATE_HZ;
  localparam int          WCNT_W           = 16;

  // Datapath widths
  localparam int CH_W       = 20;
  localparam int GAIN_W     = 12;
  localparam int GAIN_SHIFT = 12;
  localparam int FACT_W     = 14;
  localparam int PW_W       = 24;
  localparam int PROD_LSB   = 17;
  localparam int EN_W       = 40;
  localparam int LPF_SHIFT  = 8;
  localparam logic signed [FACT_W-1:0] GAIN_ONE = 14'sh1000;

  // Register map, byte addresses
  localparam int             ADDR_W        = 5;
  localparam logic [ADDR_W-1:0] OFS_ENERGY_LO = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_ENERGY_HI = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_WAVEFORM  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_MODE      = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_GAIN      = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK      = 5'h18;

  // Mode register fields
  localparam int MODE_RATE_LSB = 11;
  localparam int MODE_SRC_LSB  = 13;
  localparam logic [1:0] WAVE_SRC_POWER = 2'h0;

  // Status and mask bit positions
  localparam int IRQ_W   = 4;
  localparam int ST_HALF = 0;
  localparam int ST_OVF  = 1;
  localparam int ST_UDF  = 2;
  localparam int ST_WAVE = 3;

  // Reset values
  localparam logic [GAIN_W-1:0] GAIN_RST   = 12'h000;
  localparam logic [1:0]        RATE_RST   = 2'h0;
  localparam logic [1:0]        SRC_RST    = 2'h0;
  localparam logic [IRQ_W-1:0]  MASK_RST   = 4'h0;
  localparam logic [EN_W-1:0]   ENERGY_RST = 40'h00_0000_0000;

endpackage : energy_meter_pkg

/* File: design/power_lowpass_filter.sv */
`timescale 1ns/100ps
module power_lowpass_filter
  import energy_meter_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   in_valid,
  input  wire logic signed [PW_W-1:0] in_data,
  output logic signed [PW_W-1:0]      out_data
);

  typedef struct packed {
    logic signed [PW_W+LPF_SHIFT-1:0] acc;
  } lpf_state_t;

  lpf_state_t st;
  lpf_state_t next_st;

  // Single-pole IIR, keeps the dc part of the product
  always_comb begin
    next_st = st;
    if (in_valid) begin
      next_st.acc = st.acc + $signed({{LPF_SHIFT{in_data[PW_W-1]}}, in_data})
                  - (st.acc >>> LPF_SHIFT);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_data = st.acc[PW_W+LPF_SHIFT-1:LPF_SHIFT];

endmodule : power_lowpass_filter

/* File: verification/active_power_energy_accumulator_tb.sv */
`timescale 1ns/100ps
module active_power_energy_accumulator_tb;
  import energy_meter_pkg::*;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              read = 1'b0;
  logic              write = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic [31:0]       writedata = '0;
  logic [CH_W-1:0]   cur_level = '0;
  logic [CH_W-1:0]   volt_level = 20'h40000;
  logic [31:0]       readdata, rd, e0;
  logic [PW_W-1:0]   active_power;
  logic [CH_W-1:0]   current_sample, voltage_sample;
  logic              sample_valid, waitrequest, irq_n_out, irq_n_oe;
  int                n_fail = 0;
  int                samples_checked = 0;
  time               t1, t2;

  always #10 clk = ~clk;

  adc_sample_source u_adc_sample_source (.clk(clk), .reset(reset), .cur_level(cur_level),
    .volt_level(volt_level), .sample_valid(sample_valid), .current_sample(current_sample),
    .voltage_sample(voltage_sample));
  active_power_energy_accumulator #(.WAVE_BASE_CYCLES(16)) u_active_power_energy_accumulator (
    .clk(clk), .reset(reset), .sample_valid(sample_valid), .current_sample(current_sample),
    .voltage_sample(voltage_sample), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .active_power(active_power));

  task finish_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      n_fail++;
      finish_test();
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wait_irq(output time t);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (irq_n_oe !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      n_fail++;
      finish_test();
    end
    t = $time;
  endtask : wait_irq

  // Let the filter settle, then check power and twenty energy steps
  task automatic settle(input logic [CH_W-1:0] c, input logic [11:0] g, input logic [23:0] p);
    logic [31:0] got_d;
    logic [31:0] exp_d;
    exp_d = {{8{p[23]}}, p} * 32'd20;
    cur_level <= c;
    bus(1'b1, OFS_GAIN, {20'h0, g});
    bus(1'b0, OFS_GAIN, 32'h0);
    chk(rd[11:0], g);
    repeat (17000) @(negedge clk);
    chk(active_power, p);
    bus(1'b0, OFS_ENERGY_LO, 32'h0);
    e0 = rd;
    repeat (1097) @(posedge clk);
    bus(1'b0, OFS_ENERGY_LO, 32'h0);
    got_d = rd - e0;
    chk(got_d, exp_d);
    bus(1'b0, OFS_ENERGY_HI, 32'h0);
    chk(rd, 32'h0);
  endtask : settle

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 5'(4 * i), 32'h0);
      if (i != 2) chk(rd, 32'h0);
    end
    chk(irq_n_oe, 1'b0);
    settle(20'h40000, 12'h000, 24'h080000);
    settle(20'h40000, 12'h7FF, 24'h0BFF80);
    settle(20'h40000, 12'h800, 24'h040000);
    settle(20'hC0000, 12'h000, 24'hF80000);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, OFS_MASK, 32'h0);
      bus(1'b1, OFS_STATUS, 32'h8);
      @(negedge clk);
      chk(irq_n_oe, 1'b0);
      bus(1'b1, OFS_MODE, 32'(r) << MODE_RATE_LSB);
      bus(1'b1, OFS_MASK, 32'h8);
      wait_irq(t1);
      bus(1'b1, OFS_STATUS, 32'h8);
      wait_irq(t2);
      chk(40'((t2 - t1) / 20), 40'(16 << r));
    end
    bus(1'b0, OFS_WAVEFORM, 32'h0);
    chk(rd[23:0], 24'hF80000);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_WAVE], 1'b1);
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule : active_power_energy_accumulator_tb

/* File: verification/adc_sample_source.sv */
`timescale 1ns/100ps
module adc_sample_source
  import energy_meter_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic [CH_W-1:0] cur_level,
  input  wire logic [CH_W-1:0] volt_level,
  output logic                 sample_valid = 1'b0,
  output logic [CH_W-1:0]      current_sample = '0,
  output logic [CH_W-1:0]      voltage_sample = '0
);
  logic [1:0] phase = 2'h0;

  // One pair every four clocks, junk on the lines outside the hold time
  always @(posedge clk) begin
    phase <= reset ? 2'h0 : phase + 2'h1;
    sample_valid <= !reset && phase == 2'h3;
    current_sample <= (phase == 2'h3) ? cur_level : ~current_sample;
    voltage_sample <= (phase == 2'h3) ? volt_level
                    : (phase == 2'h0) ? voltage_sample : ~voltage_sample;
  end
endmodule : adc_sample_source

/* File: verification/energy_acc_monitor.sv */
`timescale 1ns/100ps
module energy_acc_monitor
  import energy_meter_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic                   sample_valid,
  input wire logic [ADDR_W-1:0]      address,
  input wire logic                   read,
  input wire logic                   write,
  input wire logic [31:0]            writedata,
  input wire logic [3:0]             byteenable,
  input wire logic [31:0]            readdata,
  input wire logic                   waitrequest,
  input wire logic                   irq_n_out,
  input wire logic                   irq_n_oe,
  input wire logic signed [PW_W-1:0] active_power
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  AST_WAIT_START: assert property ($rose(read) |-> waitrequest)
    else $error("no wait cycle");
  AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait too long");
  AST_IDLE: assert property (!(read || write) |-> !waitrequest)
    else $error("wait while idle");
  AST_PIN_LOW: assert property (irq_n_out == 1'b0)
    else $error("pin data not low");
  AST_RESET_OUT: assert property (disable iff (1'b0) reset |=> !irq_n_oe && active_power == 0)
    else $error("outputs not cleared");
  AST_POWER_HOLD: assert property (!sample_valid |-> ##3 $stable(active_power))
    else $error("power moved without sample");
  AST_MASK_OFF: assert property (write && !waitrequest && address == OFS_MASK
    && byteenable[0] && writedata[3:0] == 4'h0 |=> !irq_n_oe) else $error("irq not masked");
  AST_UNMAP: assert property (read && !waitrequest && address > 5'h18 |-> readdata == 0)
    else $error("unmapped read not zero");
endmodule : energy_acc_monitor

bind active_power_energy_accumulator energy_acc_monitor u_energy_acc_monitor (
  .clk(clk), .reset(reset), .sample_valid(sample_valid), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
  .active_power(active_power));
